// [rtl/wstor_pkg.sv]
// shared constants and carriers for the word storage controller
// assumes a 50 MHz mclk; pin timing counts are derived from ns figures
package wstor_pkg;
  localparam int WSTOR_WORDS      = 4;
  localparam int WSTOR_BITS       = 2;
  localparam int WSTOR_WIDX_W     = 2;
  localparam int WSTOR_CLK_NS     = 20;
  // write pulse must last the full write time
  localparam int WSTOR_WRITE_NS   = 45;
  // least gap between read pulses
  localparam int WSTOR_RDGAP_NS   = 25;
  // read delay before the outputs are valid
  localparam int WSTOR_RDLY_NS    = 25;
  // least times round up
  localparam int WSTOR_WRITE_CYC  =
    (WSTOR_WRITE_NS + WSTOR_CLK_NS - 1) / WSTOR_CLK_NS;
  localparam int WSTOR_RDGAP_CYC  =
    (WSTOR_RDGAP_NS + WSTOR_CLK_NS - 1) / WSTOR_CLK_NS;
  localparam int WSTOR_RDLY_CYC   =
    (WSTOR_RDLY_NS + WSTOR_CLK_NS - 1) / WSTOR_CLK_NS;
  localparam int WSTOR_CNT_W      = 3;

  // user request
  typedef struct packed {
    logic                    wr_en;
    logic [WSTOR_WORDS-1:0]  wr_words;
    logic [WSTOR_BITS-1:0]   wr_data;
    logic                    rd_en;
    logic [WSTOR_WIDX_W-1:0] rd_word;
  } wstor_req_t;

  // pins toward the storage cell
  typedef struct packed {
    logic [WSTOR_WORDS-1:0]  wsel;
    logic [WSTOR_WORDS-1:0]  rsel;
    logic [WSTOR_BITS-1:0]   din;
  } wstor_pins_t;

  typedef enum logic [1:0] {
    WSTOR_R_IDLE = 2'b00,
    WSTOR_R_SEL  = 2'b01,
    WSTOR_R_GAP  = 2'b10
  } wstor_rstate_t;

  typedef enum logic [0:0] {
    WSTOR_W_IDLE = 1'b0,
    WSTOR_W_HOLD = 1'b1
  } wstor_wstate_t;
endpackage

// [rtl/wstor_sync.sv]
// two flip-flop synchroniser for the wired-or data lines from the cell
// assumes the cell outputs are asynchronous to mclk
module wstor_sync
  import wstor_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic [WSTOR_BITS-1:0] async_in,
  output logic      [WSTOR_BITS-1:0] sync_out
);
  logic [WSTOR_BITS-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// [rtl/wstor_ctrl.sv]
// controller driving a four word, two bit static storage cell
// assumes the cell outputs of all words are wired-or onto dout_pin
//
// Overview of operation
// - two write selects together store the same data in both words.
// - write selects stay high for the full 45 ns write time.
// - read pulses are separated by at least 25 ns.
// - cell outputs of different words are wired-or onto shared lines.
module wstor_ctrl
  import wstor_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire wstor_req_t              req,
  output logic                         wr_ready,
  output logic                         rd_ready,
  output logic                         rd_valid,
  output logic      [WSTOR_BITS-1:0]   rd_data,
  output wstor_pins_t                  pins,
  input  wire logic [WSTOR_BITS-1:0]   dout_pin
);
  wstor_wstate_t           wst_reg;
  wstor_rstate_t           rst_reg;
  logic [WSTOR_CNT_W-1:0]  wcnt_reg;
  logic [WSTOR_CNT_W-1:0]  rcnt_reg;
  logic [WSTOR_BITS-1:0]   dout_sync;
  logic                    wr_take;
  logic                    rd_take;
  logic                    rd_clash;
  logic [WSTOR_WORDS-1:0]  wsel_reg; // one select per word
  logic [WSTOR_WORDS-1:0]  rsel_reg;
  logic [WSTOR_BITS-1:0]   din_reg;

  wstor_sync u_sync
  (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in (dout_pin),
    .sync_out (dout_sync)
  );

  // pin bundle straight from the select and data flops, one owner each
  assign pins = '{wsel: wsel_reg, rsel: rsel_reg, din: din_reg};

  // a read aimed at a word under write waits; other words go ahead
  // a write taken on the same edge counts too, so a read never starts on a word under write
  assign rd_clash = ((wst_reg == WSTOR_W_HOLD) && wsel_reg[req.rd_word])
                 || (wr_take && req.wr_words[req.rd_word]);
  assign wr_take  = req.wr_en && wr_ready && (req.wr_words != '0);
  assign rd_take  = req.rd_en && rd_ready && !rd_clash;

  // write sequencer: whole-word selects held for the write time
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wst_reg   <= WSTOR_W_IDLE;
      wcnt_reg  <= '0;
      wsel_reg  <= '0;
      din_reg   <= '0;
      wr_ready  <= 1'b1;
    end
    else
    begin
      case (wst_reg)
        WSTOR_W_IDLE:
        begin
          if (wr_take)
          begin
            wsel_reg  <= req.wr_words;
            din_reg   <= req.wr_data;
            wcnt_reg  <= WSTOR_CNT_W'(WSTOR_WRITE_CYC - 1);
            wr_ready  <= 1'b0;
            wst_reg   <= WSTOR_W_HOLD;
          end
        end
        WSTOR_W_HOLD:
        begin
          if (wcnt_reg == '0)
          begin
            wsel_reg  <= '0;
            wr_ready  <= 1'b1;
            wst_reg   <= WSTOR_W_IDLE;
          end
          else
          begin
            wcnt_reg <= wcnt_reg - 1'b1;
          end
        end
        default:
        begin
          wst_reg <= WSTOR_W_IDLE;
        end
      endcase
    end
  end

  // read sequencer: one select, wait read delay plus sync, then gap
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_reg   <= WSTOR_R_IDLE;
      rcnt_reg  <= '0;
      rsel_reg  <= '0;
      rd_ready  <= 1'b1;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end
    else
    begin
      rd_valid <= 1'b0;
      case (rst_reg)
        WSTOR_R_IDLE:
        begin
          if (rd_take)
          begin
            rsel_reg  <= WSTOR_WORDS'(1) << req.rd_word;
            rcnt_reg  <= WSTOR_CNT_W'(WSTOR_RDLY_CYC + 1);
            rd_ready  <= 1'b0;
            rst_reg   <= WSTOR_R_SEL;
          end
        end
        WSTOR_R_SEL:
        begin
          if (rcnt_reg == '0)
          begin
            rd_data   <= dout_sync;
            rd_valid  <= 1'b1;
            rsel_reg  <= '0;
            rcnt_reg  <= WSTOR_CNT_W'(WSTOR_RDGAP_CYC - 1);
            rst_reg   <= WSTOR_R_GAP;
          end
          else
          begin
            rcnt_reg <= rcnt_reg - 1'b1;
          end
        end
        WSTOR_R_GAP:
        begin
          if (rcnt_reg == '0)
          begin
            rd_ready <= 1'b1;
            rst_reg  <= WSTOR_R_IDLE;
          end
          else
          begin
            rcnt_reg <= rcnt_reg - 1'b1;
          end
        end
        default:
        begin
          rst_reg <= WSTOR_R_IDLE;
        end
      endcase
    end
  end

  // write selects hold for at least the write time
  sequence s_wr_start;
    $rose(|pins.wsel);
  endsequence
  a_write_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    s_wr_start |-> (|pins.wsel)[*3] ##1 !(|pins.wsel))
    else $error("write select width wrong");

  a_wsel_stable: assert property (@(posedge mclk) disable iff (!arst_n)
    (|pins.wsel) && $past(|pins.wsel) |-> $stable(pins.wsel)
      && $stable(pins.din))
    else $error("write select or data changed mid write");

  a_rsel_onehot: assert property (@(posedge mclk) disable iff (!arst_n)
    $onehot0(pins.rsel))
    else $error("more than one read select");

  a_read_gap: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(|pins.rsel) |-> !(|pins.rsel)[*2])
    else $error("read pulses too close");

  a_read_valid: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(|pins.rsel) |-> ##4 rd_valid)
    else $error("read answer not on time");

  a_read_nocl: assert property (@(posedge mclk) disable iff (!arst_n)
    (|(pins.rsel & pins.wsel)) |-> $past(|(pins.rsel & pins.wsel))
      || $past(rst_reg != WSTOR_R_IDLE))
    else $error("read started on word under write");

  a_write_req: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_take |=> pins.wsel == $past(req.wr_words)
      && pins.din == $past(req.wr_data))
    else $error("write selects do not match request");

  a_read_ready: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_valid |-> !rd_ready ##1 !rd_ready ##1 rd_ready)
    else $error("read ready timing wrong");

  // a read refused for a clash leaves the read side idle
  a_clash_wait: assert property (@(posedge mclk) disable iff (!arst_n)
    req.rd_en && rd_ready && rd_clash |=> rd_ready && !(|pins.rsel))
    else $error("read taken on word under write");

  // write ready stays low over the whole write pulse
  sequence s_wr_busy;
    !wr_ready [*3];
  endsequence
  a_write_ready: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_take |=> s_wr_busy ##1 wr_ready)
    else $error("write ready back at wrong time");

  // read answer is a one cycle pulse, data then holds
  a_read_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_valid |=> !rd_valid && $stable(rd_data))
    else $error("read answer did not hold");

  // one read select stands over read delay plus sync
  sequence s_rd_start;
    $rose(|pins.rsel);
  endsequence
  a_read_width: assert property (@(posedge mclk) disable iff (!arst_n)
    s_rd_start |-> (|pins.rsel)[*4] ##1 !(|pins.rsel))
    else $error("read select width wrong");
endmodule

// [bench/wstor_cell_model.sv]
// behavioural model of the four word, two bit storage cell
// assumes selects and data come from the controller pins, outputs wired-or
module wstor_cell_model
  import wstor_pkg::*;
(
  input  wire wstor_pins_t           pins,
  output logic [WSTOR_BITS-1:0]      dout
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [WSTOR_BITS-1:0] mem [WSTOR_WORDS];
  logic [WSTOR_BITS-1:0] or_v;

  // each raised write select latches the shared data, words apart
  always @*
  begin
    for (int i = 0; i < WSTOR_WORDS; i++)
      if (pins.wsel[i]) mem[i] = pins.din;
  end

  // selected words only, wired-or; idle line pulled low; reads keep data
  always @*
  begin
    or_v = '0;
    for (int i = 0; i < WSTOR_WORDS; i++)
      if (pins.rsel[i]) or_v |= mem[i];
  end

  assign #25 dout = or_v; // read delay
endmodule

// [bench/wstor_ctrl_tb.sv]
// self-checking bench for the word storage controller
// assumes the cell model answers on dout_pin after its read delay
module wstor_ctrl_tb
  import wstor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [3:0] w; logic [1:0] d; logic [1:0] r;} wstor_row_t;
  logic        mclk, arst_n, wr_ready, rd_ready, rd_valid;
  logic [1:0]  rd_data, dout_pin;
  wstor_req_t  req;
  wstor_pins_t pins;
  int          n_mismatch = 0, check_count = 0, cyc = 0, wlen = 0, rgap = 9;
  int          k = 0;
  wstor_row_t  rows [4] = '{'{4'h1, 2'h1, 2'h0}, '{4'h2, 2'h2, 2'h1},
                           '{4'h4, 2'h3, 2'h2}, '{4'h8, 2'h0, 2'h3}};

  wstor_ctrl i_wstor_ctrl (.mclk(mclk), .arst_n(arst_n), .req(req),
    .wr_ready(wr_ready), .rd_ready(rd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .pins(pins), .dout_pin(dout_pin));
  wstor_cell_model i_wstor_cell_model (.pins(pins), .dout(dout_pin));

  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // pin watch: write pulse length, read gap, one read select at most
  always @(negedge mclk)
    if (arst_n)
    begin
      chk({3'h0, $countones(pins.rsel) <= 1}, 4'h1);
      if (pins.wsel != 0) wlen++;
      else if (wlen != 0)
      begin
        chk(wlen[3:0], 4'h3);
        wlen = 0;
      end
      if (pins.rsel != 0)
      begin
        if (rgap > 0) chk({3'h0, rgap >= 2}, 4'h1);
        rgap = 0;
      end
      else rgap++;
    end
    else
      wlen = 0; // a write cut by reset is not a short write

  // one write and/or read request on an edge with both ready; ready is
  // looked at on the falling edge so a just-launched busy is seen
  task automatic xfer(input logic dw, input logic [3:0] w,
                      input logic [1:0] d, input logic dr,
                      input logic [1:0] r, input logic [1:0] e);
    int n;
    @(negedge mclk);
    for (n = 0; n < 20 && !(wr_ready && rd_ready); n++) @(negedge mclk);
    @(posedge mclk);
    req.wr_en    <= dw;
    req.wr_words <= w;
    req.wr_data  <= d;
    req.rd_en    <= dr;
    req.rd_word  <= r;
    @(posedge mclk);
    req.wr_en <= 1'b0;
    req.rd_en <= 1'b0;
    @(negedge mclk);
    if (dw) chk({3'h0, wr_ready}, 4'h0);
    if (dr)
    begin
      chk({3'h0, rd_ready}, 4'h0);
      for (n = 0; n < 12 && rd_valid !== 1'b1; n++) @(negedge mclk);
      chk({3'h0, rd_valid}, 4'h1);
      chk({2'h0, rd_data}, {2'h0, e});
      @(negedge mclk);
      chk({3'h0, rd_valid}, 4'h0);
      chk({2'h0, rd_data}, {2'h0, e});
    end
  endtask

  initial
  begin
    req    = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge mclk);
    chk({1'b0, wr_ready, rd_ready, rd_valid}, 4'h6);
    chk(pins.wsel | pins.rsel | {2'h0, pins.din}, 4'h0);
    chk({2'h0, rd_data}, 4'h0);
    arst_n <= 1'b1;
    $display("test reset done");
    // table: write each word, then read it back
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i].w, rows[i].d, 1'b0, 2'h0, 2'h0);
      xfer(1'b0, 4'h0, 2'h0, 1'b1, rows[i].r, rows[i].d);
    end
    $display("test rows done");
    xfer(1'b0, 4'h0, 2'h0, 1'b1, 2'h2, 2'h3);
    xfer(1'b0, 4'h0, 2'h0, 1'b1, 2'h2, 2'h3);
    $display("test reread done");
    xfer(1'b1, 4'h5, 2'h2, 1'b0, 2'h0, 2'h0);
    xfer(1'b0, 4'h0, 2'h0, 1'b1, 2'h0, 2'h2);
    xfer(1'b0, 4'h0, 2'h0, 1'b1, 2'h2, 2'h2);
    $display("test dual write done");
    xfer(1'b1, 4'h2, 2'h3, 1'b1, 2'h3, 2'h0);
    xfer(1'b0, 4'h0, 2'h0, 1'b1, 2'h1, 2'h3);
    $display("test overlap done");
    // mid-run reset cuts a write; pins drop, readies return, work resumes
    xfer(1'b1, 4'h8, 2'h2, 1'b0, 2'h0, 2'h0);
    @(posedge mclk);
    arst_n <= 1'b0;
    @(negedge mclk);
    chk({1'b0, wr_ready, rd_ready, rd_valid}, 4'h6);
    chk(pins.wsel | pins.rsel, 4'h0);
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    xfer(1'b1, 4'h8, 2'h1, 1'b0, 2'h0, 2'h0);
    xfer(1'b0, 4'h0, 2'h0, 1'b1, 2'h3, 2'h1);
    $display("test mid reset done");
    // read of a word under write waits until that write has ended
    for (k = 0; k < 20 && !(wr_ready && rd_ready); k++) @(negedge mclk);
    @(posedge mclk);
    req.wr_en    <= 1'b1;
    req.wr_words <= 4'h1;
    req.wr_data  <= 2'h1;
    req.rd_en    <= 1'b1;
    req.rd_word  <= 2'h0;
    @(posedge mclk);
    req.wr_en <= 1'b0;
    @(negedge mclk);
    for (k = 0; k < 20 && rd_ready; k++) @(negedge mclk);
    @(posedge mclk);
    req.rd_en <= 1'b0;
    chk(k[3:0], 4'(WSTOR_WRITE_CYC + 1));
    for (k = 0; k < 12 && rd_valid !== 1'b1; k++) @(negedge mclk);
    chk({3'h0, rd_valid}, 4'h1);
    chk({2'h0, rd_data}, 4'h1);
    $display("test clash done");
    final_report();
  end
endmodule
